// [logic/rcf_alarm_match.sv]
`timescale 1ns/100ps
module rcf_alarm_match (
   input  wire logic                i_ref_clk,  // System clock
   input  wire logic                i_rstn,     // Async reset, active low
   input  wire logic                i_tick,     // Timekeeping update pulse
   input  wire rcf_pkg::rcf_time_t  i_time,     // Current time and date
   input  wire rcf_pkg::rcf_alarm_t i_alarm,    // Alarm values and masks
   output logic                     o_match     // One-cycle match pulse
);
   import rcf_pkg::*;

   // ----------------------------------------------------------------
   // Per-field compare
   // ----------------------------------------------------------------
   logic [4:0] field_ok;
   logic [7:0] cur_f [5];
   logic [7:0] alm_f [5];

   assign cur_f[0] = i_time.seconds;
   assign cur_f[1] = i_time.minutes;
   assign cur_f[2] = i_time.hours;
   assign cur_f[3] = i_time.date;
   assign cur_f[4] = i_time.month;
   assign alm_f[0] = i_alarm.value.seconds;
   assign alm_f[1] = i_alarm.value.minutes;
   assign alm_f[2] = i_alarm.value.hours;
   assign alm_f[3] = i_alarm.value.date;
   assign alm_f[4] = i_alarm.value.month;

   // Masked field always agrees
   for (genvar g = 0; g < 5; g++) begin : g_field
      assign field_ok[g] = i_alarm.mask[g] | (cur_f[g] == alm_f[g]);
   end

   // Sample only on the update so one match gives one pulse
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_match <= 1'b0;
      end else begin
         o_match <= i_tick & (&field_ok);
      end
   end
endmodule : rcf_alarm_match

// [logic/rcf_flags_regs.sv]
`timescale 1ns/100ps
// Summary of operation
// - Century counts 0-99 as two BCD digits; writes stored as written
// - Status byte: flags high, zero, controls low
// - Alarm flag set on unmasked time match
// - Host writes never change alarm flag
// - Reading status byte clears alarm flag
// - Mask bit one drops field from compare
// - Oscillator-fail set if dead after 5 ms
// - Oscillator-fail cleared only by host zero write
module rcf_flags_regs #(
   parameter int OSC_CHECK_CYCLES = rcf_pkg::OSC_CHECK_CYC  // Power-up oscillator window
)(
   input  wire logic                        i_ref_clk,     // System clock
   input  wire logic                        i_rstn,        // Async reset, active low
   input  wire logic                        i_ce_n,        // Chip enable pin
   input  wire logic                        i_we_n,        // Write enable pin
   input  wire logic                        i_oe_n,        // Output enable pin
   input  wire logic [rcf_pkg::ADDR_W-1:0]  i_addr,        // Address pins
   input  wire logic [7:0]                  i_dq,          // Data pins, in
   output logic [7:0]                       o_dq,          // Data pins, out
   output logic                             o_dq_oe,       // High while driving data
   input  wire logic                        i_tick,        // Timekeeping update pulse
   input  wire rcf_pkg::rcf_time_t          i_time,        // Current time and date
   input  wire rcf_pkg::rcf_alarm_t         i_alarm,       // Alarm values and masks
   input  wire logic                        i_year_wrap,   // Year rolled 99 to 00
   input  wire logic                        i_dog_timeout, // Watchdog expiry pulse
   input  wire logic                        i_supply_fail, // Supply below threshold pulse
   input  wire logic                        i_osc_enable,  // Oscillator enabled
   input  wire logic                        i_osc_running, // Oscillator running
   output logic [7:0]                       o_century,     // Century count, BCD
   output logic [7:0]                       o_flags,       // Status byte
   output logic                             o_cal_sel,     // Calibration select
   output logic                             o_write_hold,  // Write hold
   output logic                             o_read_hold    // Read hold
);
   import rcf_pkg::*;

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   rcf_bus_t pin_meta_q;
   rcf_bus_t pin_q;
   rcf_bus_t pin_in;

   assign pin_in = '{ce_n: i_ce_n, we_n: i_we_n, oe_n: i_oe_n, addr: i_addr, dq: i_dq};

   // Whole bus through two stages; only the second is read
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pin_meta_q <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
         pin_q      <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
      end else begin
         pin_meta_q <= pin_in;
         pin_q      <= pin_meta_q;
      end
   end

   // ----------------------------------------------------------------
   // Access decode
   // ----------------------------------------------------------------
   logic              rd_act;
   logic              wr_act;
   logic              rd_act_q;
   logic              wr_act_q;
   logic              rd_flags_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [7:0]        wr_data_q;
   logic              rd_end_flags;
   logic              wr_end;

   // Write takes priority over output enable, as on an SRAM
   assign rd_act       = !pin_q.ce_n && !pin_q.oe_n && pin_q.we_n;
   assign wr_act       = !pin_q.ce_n && !pin_q.we_n;
   assign rd_end_flags = rd_act_q && !rd_act && rd_flags_q;
   assign wr_end       = wr_act_q && !wr_act;

   // Track strobes; address and data captured while write is open,
   // committed at its end when both are settled
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         rd_act_q   <= 1'b0;
         wr_act_q   <= 1'b0;
         rd_flags_q <= 1'b0;
         wr_addr_q  <= '0;
         wr_data_q  <= DATA_IDLE;
      end else begin
         rd_act_q <= rd_act;
         wr_act_q <= wr_act;
         if (rd_act) begin
            rd_flags_q <= (pin_q.addr == FLAGS_ADDR);
         end
         if (wr_act) begin
            wr_addr_q <= pin_q.addr;
            wr_data_q <= pin_q.dq;
         end
      end
   end

   logic wr_flags;
   logic wr_century;
   assign wr_flags   = wr_end && (wr_addr_q == FLAGS_ADDR);
   assign wr_century = wr_end && (wr_addr_q == CENTURY_ADDR);

   // ----------------------------------------------------------------
   // Alarm match
   // ----------------------------------------------------------------
   logic alarm_hit;

   rcf_alarm_match u_match (
      .i_ref_clk (i_ref_clk),
      .i_rstn    (i_rstn),
      .i_tick    (i_tick),
      .i_time    (i_time),
      .i_alarm   (i_alarm),
      .o_match   (alarm_hit)
   );

   // ----------------------------------------------------------------
   // Event flags
   // ----------------------------------------------------------------
   logic dog_q;
   logic alarm_q;
   logic supply_q;
   logic osc_fail_q;

   // Read of the byte clears after the data has gone out; a new
   // event in the same cycle wins over the clear
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         alarm_q <= FLAGS_RST[ALARM_BIT];
         dog_q   <= FLAGS_RST[DOG_BIT];
      end else begin
         if (alarm_hit) begin
            alarm_q <= 1'b1;
         end else if (rd_end_flags) begin
            alarm_q <= 1'b0;
         end
         if (i_dog_timeout) begin
            dog_q <= 1'b1;
         end else if (rd_end_flags) begin
            dog_q <= 1'b0;
         end
      end
   end

   // Power-fail flag: sticky until reset, host cannot touch it
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         supply_q <= FLAGS_RST[SUPPLY_BIT];
      end else if (i_supply_fail) begin
         supply_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Oscillator check
   // ----------------------------------------------------------------
   logic [31:0] osc_cnt_q;
   logic        osc_done_q;

   // One-shot window after power-up; no later check by design
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_cnt_q  <= '0;
         osc_done_q <= 1'b0;
      end else if (!osc_done_q) begin
         if (osc_cnt_q >= 32'(OSC_CHECK_CYCLES - 1)) begin
            osc_done_q <= 1'b1;
         end else begin
            osc_cnt_q <= osc_cnt_q + 32'h00000001;
         end
      end
   end

   logic osc_dead;
   assign osc_dead = !osc_done_q && (osc_cnt_q >= 32'(OSC_CHECK_CYCLES - 1))
                     && i_osc_enable && !i_osc_running;

   // Only a host zero writes clear it; a one written is ignored
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_fail_q <= FLAGS_RST[OSC_BIT];
      end else if (osc_dead) begin
         osc_fail_q <= 1'b1;
      end else if (wr_flags && !wr_data_q[OSC_BIT]) begin
         osc_fail_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Control bits
   // ----------------------------------------------------------------
   logic cal_q;
   logic whold_q;
   logic rhold_q;

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cal_q   <= FLAGS_RST[CAL_BIT];
         whold_q <= FLAGS_RST[WHOLD_BIT];
         rhold_q <= FLAGS_RST[RHOLD_BIT];
      end else if (wr_flags) begin
         cal_q   <= wr_data_q[CAL_BIT];
         whold_q <= wr_data_q[WHOLD_BIT];
         rhold_q <= wr_data_q[RHOLD_BIT];
      end
   end

   logic [7:0] flags_byte;
   always_comb begin
      flags_byte            = 8'h00;
      flags_byte[DOG_BIT]   = dog_q;
      flags_byte[ALARM_BIT] = alarm_q;
      flags_byte[SUPPLY_BIT]= supply_q;
      flags_byte[OSC_BIT]   = osc_fail_q;
      flags_byte[ZERO_BIT]  = 1'b0;
      flags_byte[CAL_BIT]   = cal_q;
      flags_byte[WHOLD_BIT] = whold_q;
      flags_byte[RHOLD_BIT] = rhold_q;
   end

   // ----------------------------------------------------------------
   // Century count
   // ----------------------------------------------------------------
   logic [7:0] century_q;

   // Host write wins; digits above nine are stored as written,
   // a later carry then handles them like nine and rolls them to zero
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         century_q <= CENTURY_RST;
      end else if (wr_century) begin
         century_q <= wr_data_q;
      end else if (i_year_wrap && !whold_q) begin
         if (century_q[3:0] >= BCD_MAX) begin
            century_q[3:0] <= 4'h0;
            century_q[7:4] <= (century_q[7:4] >= BCD_MAX) ? 4'h0 : century_q[7:4] + 4'h1;
         end else begin
            century_q[3:0] <= century_q[3:0] + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data and outputs
   // ----------------------------------------------------------------
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_dq    <= DATA_IDLE;
         o_dq_oe <= 1'b0;
      end else begin
         o_dq_oe <= rd_act && ((pin_q.addr == FLAGS_ADDR) || (pin_q.addr == CENTURY_ADDR));
         if (pin_q.addr == FLAGS_ADDR) begin
            o_dq <= flags_byte;
         end else if (pin_q.addr == CENTURY_ADDR) begin
            o_dq <= century_q;
         end else begin
            o_dq <= DATA_IDLE;
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_century    <= CENTURY_RST;
         o_flags      <= FLAGS_RST;
         o_cal_sel    <= FLAGS_RST[CAL_BIT];
         o_write_hold <= FLAGS_RST[WHOLD_BIT];
         o_read_hold  <= FLAGS_RST[RHOLD_BIT];
      end else begin
         o_century    <= century_q;
         o_flags      <= flags_byte;
         o_cal_sel    <= cal_q;
         o_write_hold <= whold_q;
         o_read_hold  <= rhold_q;
      end
   end
endmodule : rcf_flags_regs

// [logic/rcf_pkg.sv]
package rcf_pkg;
   // ----------------------------------------------------------------
   // Map and field layout
   // ----------------------------------------------------------------
   localparam int            ADDR_W       = 19;
   localparam logic [18:0]   FLAGS_ADDR   = 19'h7FFF0;
   localparam logic [18:0]   CENTURY_ADDR = 19'h7FFF1;
   localparam int            DOG_BIT      = 7;
   localparam int            ALARM_BIT    = 6;
   localparam int            SUPPLY_BIT   = 5;
   localparam int            OSC_BIT      = 4;
   localparam int            ZERO_BIT     = 3;
   localparam int            CAL_BIT      = 2;
   localparam int            WHOLD_BIT    = 1;
   localparam int            RHOLD_BIT    = 0;
   localparam logic [7:0]    FLAGS_RST    = 8'h00;
   localparam logic [7:0]    CENTURY_RST  = 8'h00;
   localparam logic [3:0]    BCD_MAX      = 4'h9;
   localparam logic [7:0]    DATA_IDLE    = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam longint        CLK_HZ       = 125000000;
   localparam longint        OSC_CHECK_US = 5000;
   // Latest time, so round down
   localparam int            OSC_CHECK_CYC = int'((OSC_CHECK_US * CLK_HZ) / 1000000);

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] month;
      logic [7:0] date;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } rcf_time_t;

   typedef struct packed {
      rcf_time_t  value;
      logic [4:0] mask;   // 1 removes the field; bit 0 = seconds .. bit 4 = month
   } rcf_alarm_t;

   typedef struct packed {
      logic              ce_n;
      logic              we_n;
      logic              oe_n;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        dq;
   } rcf_bus_t;
endpackage : rcf_pkg

// [test/rcf_flags_regs_assertions.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Pin-level checks of the flags block
// ----------------------------------------
module rcf_flags_regs_assertions #(
   parameter int OSC_CHECK_CYCLES = rcf_pkg::OSC_CHECK_CYC  // Power-up oscillator window
)(
   input wire logic                        i_ref_clk,     // System clock
   input wire logic                        i_rstn,        // Async reset, active low
   input wire logic                        i_ce_n,        // Chip enable pin
   input wire logic                        i_we_n,        // Write enable pin
   input wire logic [rcf_pkg::ADDR_W-1:0]  i_addr,        // Address pins
   input wire logic [7:0]                  i_dq,          // Data pins, in
   input wire logic                        o_dq_oe,       // Data drive enable
   input wire logic                        i_tick,        // Update pulse
   input wire rcf_pkg::rcf_time_t          i_time,        // Current time
   input wire rcf_pkg::rcf_alarm_t         i_alarm,       // Alarm values and masks
   input wire logic                        i_year_wrap,   // Year roll pulse
   input wire logic                        i_dog_timeout, // Watchdog pulse
   input wire logic                        i_osc_enable,  // Oscillator enabled
   input wire logic                        i_osc_running, // Oscillator running
   input wire logic [7:0]                  o_century,     // Century count
   input wire logic [7:0]                  o_flags        // Status byte
);
   import rcf_pkg::*;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   logic [4:0] hit;        // Per-field compare, masked fields pass
   logic       tick_hit;   // Update pulse with a full match
   logic [3:0] osc_wr_age; // Cycles since a zero write to the osc bit
   logic [7:0] cen_q;      // Century seen at the last wrap pulse

   function automatic logic [7:0] bcd_next(input logic [7:0] c);
      if (c[3:0] != BCD_MAX) return c + 8'h01;
      return (c[7:4] == BCD_MAX) ? 8'h00 : {c[7:4] + 4'h1, 4'h0};
   endfunction : bcd_next

   // Expected match worked out from the inputs alone
   always_comb begin
      for (int k = 0; k < 5; k++) begin
         hit[k] = i_alarm.mask[k] || (i_time[8*k +: 8] == i_alarm.value[8*k +: 8]);
      end
   end
   assign tick_hit = i_tick & (&hit);

   // Saturating age, so a late clear is still caught
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         osc_wr_age <= 4'hF;
      end else if (!i_ce_n && !i_we_n && i_addr == FLAGS_ADDR && !i_dq[OSC_BIT]) begin
         osc_wr_age <= 4'h0;
      end else if (osc_wr_age != 4'hF) begin
         osc_wr_age <= osc_wr_age + 4'h1;
      end
   end

   // Century captured at the wrap pulse
   always_ff @(posedge i_ref_clk) begin
      if (i_year_wrap) begin
         cen_q <= o_century;
      end
   end

   AST_ZERO_BIT: assert property (o_flags[ZERO_BIT] == 1'b0)
      else $error("status bit 3 not zero");
   AST_ALARM_SET: assert property (tick_hit |-> ##3 o_flags[ALARM_BIT])
      else $error("alarm flag not set on match");
   AST_ALARM_CAUSE: assert property ($rose(o_flags[ALARM_BIT]) |-> $past(tick_hit, 3))
      else $error("alarm flag rose without a match");
   // Drive drops one edge before the flag byte shows the clear
   AST_ALARM_CLEAR: assert property ($fell(o_flags[ALARM_BIT]) |-> $past(o_dq_oe, 2) && !$past(o_dq_oe))
      else $error("alarm flag fell without a read");
   AST_OSC_SET: assert property ($rose(o_flags[OSC_BIT]) |-> !$past(i_osc_running, 2))
      else $error("osc flag rose while running");
   AST_OSC_KEEP: assert property ($fell(o_flags[OSC_BIT]) |-> osc_wr_age < 4'h9)
      else $error("osc flag fell without a zero write");
   AST_CENTURY_WRAP: assert property (i_year_wrap |-> ##[1:4] o_century == bcd_next(cen_q))
      else $error("century did not step in BCD");
   AST_DOG_SET: assert property (i_dog_timeout |-> ##[1:3] o_flags[DOG_BIT])
      else $error("dog flag not set");
endmodule : rcf_flags_regs_assertions

bind rcf_flags_regs rcf_flags_regs_assertions #(.OSC_CHECK_CYCLES(OSC_CHECK_CYCLES)) u_chk (.*);

// [test/rcf_flags_regs_tb.sv]
`timescale 1ns/100ps
module rcf_flags_regs_tb;
   import rcf_pkg::*;
   logic       clk, rstn, tick, wrap, dog, sup, oe, prev_oe, run;
   logic [2:0] ctl;
   rcf_time_t  tm;
   rcf_alarm_t al;
   rcf_bus_t   bus;
   logic [7:0] dq, pin, flags, cen, v;
   int         num_errors, n_tests, i, m;
   logic [7:0] exp_q[$];

   // Shared data pin: device wins while it drives
   assign pin = oe ? dq : bus.dq;

   // Short power-up window keeps the run brief
   rcf_flags_regs #(.OSC_CHECK_CYCLES(20)) dut (
      .i_ref_clk(clk), .i_rstn(rstn), .i_ce_n(bus.ce_n), .i_we_n(bus.we_n),
      .i_oe_n(bus.oe_n), .i_addr(bus.addr), .i_dq(pin), .o_dq(dq), .o_dq_oe(oe),
      .i_tick(tick), .i_time(tm), .i_alarm(al), .i_year_wrap(wrap),
      .i_dog_timeout(dog), .i_supply_fail(sup), .i_osc_enable(1'b1),
      .i_osc_running(run), .o_century(cen), .o_flags(flags), .o_cal_sel(ctl[2]),
      .o_write_hold(ctl[1]), .o_read_hold(ctl[0]));
   rcf_host_model host (.i_ref_clk(clk), .o_bus(bus));

   task chk(input logic [7:0] seen, input logic [7:0] expv, input string what);
      n_tests++;
      if (seen !== expv) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, expv, seen);
      end
   endtask : chk

   task results;
      if (num_errors == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : results

   task rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      host.acc(1'b0, a, 8'h00);
   endtask : rd

   task pulse(input int which);
      @(negedge clk);
      {tick, wrap, dog, sup} = 4'(1 << which);
      @(negedge clk);
      {tick, wrap, dog, sup} = 4'h0;
      repeat (4) @(negedge clk);
   endtask : pulse

   // Read data compared on the cycle the drive comes on
   always @(negedge clk) begin
      if (oe && !prev_oe) chk(dq, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX, "rdata");
      prev_oe = oe;
   end

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      chk(8'h00, 8'h01, "run time");
      results();
   end

   initial begin
      {rstn, tick, wrap, dog, sup, prev_oe, run} = 7'h00;
      {tm, al, num_errors, n_tests} = '0;
      void'($urandom(32'h3A1857BC));
      repeat (8) @(posedge clk);
      @(negedge clk) rstn = 1'b1;
      repeat (30) @(negedge clk);
      chk(flags, 8'h10, "osc flag");
      chk(cen, CENTURY_RST, "century");
      host.acc(1'b1, FLAGS_ADDR, 8'hFF);
      chk(flags, 8'h17, "flags wr");
      chk({5'h00, ctl}, 8'h07, "controls");
      rd(FLAGS_ADDR, 8'h17);
      host.acc(1'b1, FLAGS_ADDR, 8'h00);
      chk(flags, 8'h00, "osc clear");
      chk({5'h00, ctl}, 8'h00, "controls off");
      host.acc(1'b1, 19'h7FFF2, 8'hFF);
      chk(flags | cen, 8'h00, "unmapped");
      for (i = 0; i < 4; i++) begin
         v = {4'($urandom_range(9)), 4'($urandom_range(9))};
         host.acc(1'b1, CENTURY_ADDR, v);
         rd(CENTURY_ADDR, v);
      end
      // Both digit carries: 99 to 00 and 09 to 10
      for (i = 0; i < 2; i++) begin
         host.acc(1'b1, CENTURY_ADDR, i ? 8'h09 : 8'h99);
         pulse(2);
         chk(cen, i ? 8'h10 : 8'h00, "wrap");
      end
      tm = {8'h12, 8'h31, 8'h23, 8'h59, 8'h58};
      // Each field off by one, then masked out
      for (i = 0; i < 5; i++) begin
         for (m = 0; m < 2; m++) begin
            al.value = tm;
            al.value[8*i] = ~tm[8*i];
            al.mask = 5'(m << i);
            pulse(3);
            chk({7'h0, flags[ALARM_BIT]}, 8'(m), "alarm");
            if (m == 1) begin
               host.acc(1'b1, FLAGS_ADDR, 8'h00);
               chk(flags, 8'h40, "alarm hold");
               rd(FLAGS_ADDR, 8'h40);
               chk(flags, 8'h00, "alarm clr");
            end
         end
      end
      // Dog flag clears on read, supply flag stays
      for (i = 0; i < 2; i++) begin
         pulse(i ? 0 : 1);
         pulse(i ? 0 : 2);
         chk(flags, i ? 8'h20 : 8'h80, "set flag");
         rd(FLAGS_ADDR, i ? 8'h20 : 8'h80);
         chk(flags, i ? 8'h20 : 8'h00, "read flag");
      end
      // Second power-up with a live oscillator: all clear, no osc flag
      run  = 1'b1;
      rstn = 1'b0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (30) @(negedge clk);
      chk(flags | cen, 8'h00, "second reset");
      chk(8'(exp_q.size()), 8'h00, "reads");
      results();
   end
endmodule : rcf_flags_regs_tb

// [test/rcf_host_model.sv]
`timescale 1ns/100ps
// ----------------------------------------
// Host processor on the parallel pin bus
// ----------------------------------------
module rcf_host_model (
   input  wire logic         i_ref_clk, // System clock
   output rcf_pkg::rcf_bus_t o_bus      // Strobes, address and write data
);
   import rcf_pkg::*;

   // Idle at time zero, nothing selected
   initial begin
      o_bus = '{1'b1, 1'b1, 1'b1, '0, 8'h00};
   end

   // One byte access, held 5 cycles then a 5 cycle gap; released
   // lines show the inverse so a stale value never looks valid
   task acc(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      @(negedge i_ref_clk);
      o_bus <= '{1'b0, ~wr, wr, a, d};
      repeat (5) @(negedge i_ref_clk);
      o_bus <= '{1'b1, 1'b1, 1'b1, ~a, ~d};
      repeat (5) @(negedge i_ref_clk);
   endtask : acc
endmodule : rcf_host_model
